/* File: verilog/est_timing.sv */
// Exposure, strobe and frame mode timing with AXI4-Lite registers
`timescale 1ns/1ps
// Summary of operation
// - Exposure in microseconds, clamped 16 us..400 ms
// - Strobe on output three follows exposure
// - Nonzero fixed on-time sets strobe width
// - Delay: strobe first, exposure after delay
// - Binning gives 1232 by 1024 frames
// - Binning halves least frame period
// - Per-image sets pick binning per frame
// - Constant brightness keeps LEDs on high
// - No built-in lighting forces LEDs off
// - Simulation replays stored images cyclically
module est_timing #(
  parameter logic        HAS_INT_LIGHT  = 1'b0,
  parameter int unsigned FRAME_FULL_CYC = est_pkg::FRAME_FULL_CYC,
  parameter int unsigned FRAME_BIN_CYC  = est_pkg::FRAME_BIN_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        trigger,
  output logic             sensor_expose,
  output logic             strobe_out3,
  output logic             led_on,
  output logic             led_high,
  output logic             frame_start,
  output logic             frame_sim,
  output logic             frame_binned,
  output logic [11:0]      frame_width,
  output logic [11:0]      frame_height,
  output logic [7:0]       sim_index
);
  import est_pkg::*;

  // Byte-lane merge shared by the control, exposure, on-time and delay registers
  function automatic logic [31:0] wmerge(input logic [31:0] o,
                                         input logic [31:0] n,
                                         input logic [3:0]  s);
    for (int i = 0; i < 4; i++) begin
      wmerge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction

  // Exposure limits applied on the way in
  function automatic logic [TW-1:0] clamp_us(input logic [31:0] v);
    if (v < 32'(EXP_MIN_US)) begin
      clamp_us = EXP_MIN_US;
    end else if (v > 32'(EXP_MAX_US)) begin
      clamp_us = EXP_MAX_US;
    end else begin
      clamp_us = v[TW-1:0];
    end
  endfunction

  logic [31:0]         ctrl_q;
  logic [TW-1:0]       exp_q, ont_q, dly_q;
  logic [7:0]          simn_q;
  logic [CFG_AW-1:0]   cfg_wa_q, cfg_idx_q;
  logic [CFG_DW-1:0]   cfg_rdata;
  logic                cfg_we;
  logic                wr_go, rd_go, bvalid_q, rvalid_q;
  logic [1:0]          bresp_q, rresp_q;
  logic [31:0]         rdata_q, rd_mux;
  logic                rd_hit;
  est_state_t          state_q, state_d;
  logic [5:0]          us_q;
  logic                tick;
  logic [TW-1:0]       exp_cnt_q, ont_cnt_q, dly_cnt_q, exp_l_q, ont_l_q;
  logic                fixed_q, strobe_q, sim_cur_q, bin_cur_q;
  logic [GW-1:0]       gap_q;
  logic                trig_ok, bin_sel, exp_end, ont_end;
  logic [7:0]          miss_q;
  est_illum_t          ill_eff;

  // Write channel: address and data taken together, one write at a time
  assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign cfg_we = wr_go && s_axi_awaddr[7:2] == ADDR_CFG[7:2]
                  && s_axi_wstrb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (s_axi_awaddr[7:2] > ADDR_CFG[7:2]) ? RESP_SLVERR
                                                      : RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Software registers; exposure is clamped when written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q   <= CTRL_RST;
      exp_q    <= EXP_RST_US;
      ont_q    <= '0;
      dly_q    <= '0;
      simn_q   <= SIMN_RST;
      cfg_wa_q <= '0;
    end else if (wr_go) begin
      case (s_axi_awaddr[7:2])
        ADDR_CTRL[7:2]: ctrl_q <= wmerge(ctrl_q, s_axi_wdata, s_axi_wstrb);
        ADDR_EXP[7:2]: begin
          exp_q <= clamp_us(wmerge(32'(exp_q), s_axi_wdata,
                                   s_axi_wstrb));
        end
        ADDR_ONT[7:2]: begin
          ont_q <= TW'(wmerge(32'(ont_q), s_axi_wdata, s_axi_wstrb));
        end
        ADDR_DLY[7:2]: begin
          dly_q <= TW'(wmerge(32'(dly_q), s_axi_wdata, s_axi_wstrb));
        end
        ADDR_SIMN[7:2]: begin
          if (s_axi_wstrb[0]) begin
            simn_q <= s_axi_wdata[7:0];
          end
        end
        ADDR_CFG[7:2]: begin
          if (s_axi_wstrb[2]) begin
            cfg_wa_q <= s_axi_wdata[16 +: CFG_AW];
          end
        end
        default: ;
      endcase
    end
  end

  // Per-image sets; the write address follows the same word
  est_cfg_mem u_cfg (
    .aclk    (aclk),
    .aresetn (aresetn),
    .we      (cfg_we),
    .waddr   (s_axi_wstrb[2] ? s_axi_wdata[16 +: CFG_AW] : cfg_wa_q),
    .wdata   (s_axi_wdata[CFG_DW-1:0]),
    .raddr   (cfg_idx_q),
    .rdata   (cfg_rdata)
  );

  // Read mux; state is visible through the status word
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr[7:2])
      ADDR_CTRL[7:2]: rd_mux = ctrl_q;
      ADDR_EXP[7:2]:  rd_mux = 32'(exp_q);
      ADDR_ONT[7:2]:  rd_mux = 32'(ont_q);
      ADDR_DLY[7:2]:  rd_mux = 32'(dly_q);
      ADDR_STAT[7:2]: rd_mux = {miss_q, 4'h0, cfg_idx_q, sim_index,
                                2'h0, sim_cur_q, bin_cur_q, sensor_expose,
                                strobe_q, state_q};
      ADDR_SIMN[7:2]: rd_mux = {24'h0, simn_q};
      ADDR_CFG[7:2]:  rd_mux = {12'h0, cfg_wa_q, 8'h0, cfg_rdata};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign rd_go         = s_axi_arvalid & ~rvalid_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // A trigger starts a frame only when idle and the frame period is up
  assign trig_ok = trigger && state_q == ST_IDLE && gap_q == '0;
  assign bin_sel = ctrl_q[CTRL_CFGDB] ? cfg_rdata[CFG_BIN]
                                      : ctrl_q[CTRL_BIN];
  assign tick    = us_q == US_LAST;
  assign exp_end = tick && exp_cnt_q == TW'(1);
  assign ont_end = tick && ont_cnt_q == TW'(1);

  // Microsecond prescaler restarted at trigger so counts are exact
  always_ff @(posedge aclk) begin
    if (!aresetn || trig_ok || tick) begin
      us_q <= '0;
    end else begin
      us_q <= us_q + 6'h01;
    end
  end

  // Phase sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (trig_ok && !ctrl_q[CTRL_SIMEN]) begin
          state_d = (dly_q != '0) ? ST_DELAY : ST_EXPOSE;
        end
      end
      ST_DELAY: begin
        if (tick && dly_cnt_q == TW'(1)) begin
          state_d = ST_EXPOSE;
        end
      end
      ST_EXPOSE: begin
        if (exp_end) begin
          state_d = (fixed_q && strobe_q && !ont_end) ? ST_HOLD : ST_IDLE;
        end
      end
      ST_HOLD: begin
        if (ont_end) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Counters loaded together at the trigger, stepped by the tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exp_cnt_q <= '0;
      ont_cnt_q <= '0;
      dly_cnt_q <= '0;
      exp_l_q   <= '0;
      ont_l_q   <= '0;
    end else if (trig_ok) begin
      exp_cnt_q <= exp_q;
      ont_cnt_q <= ont_q;
      dly_cnt_q <= dly_q;
      exp_l_q   <= exp_q;
      ont_l_q   <= ont_q;
    end else if (tick) begin
      if (state_q == ST_DELAY) begin
        dly_cnt_q <= dly_cnt_q - TW'(1);
      end
      if (state_q == ST_EXPOSE) begin
        exp_cnt_q <= exp_cnt_q - TW'(1);
      end
      if (ont_cnt_q != '0) begin
        ont_cnt_q <= ont_cnt_q - TW'(1);
      end
    end
  end

  // Strobe: fixed width when set, otherwise the delay and exposure window
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe_q <= 1'b0;
      fixed_q  <= 1'b0;
    end else if (trig_ok) begin
      fixed_q  <= ont_q != '0;
      strobe_q <= !ctrl_q[CTRL_SIMEN];
    end else if (fixed_q) begin
      strobe_q <= strobe_q && !ont_end;
    end else begin
      strobe_q <= state_d == ST_DELAY || state_d == ST_EXPOSE;
    end
  end

  assign sensor_expose = state_q == ST_EXPOSE;
  assign strobe_out3   = strobe_q && ctrl_q[CTRL_STREN];

  // Frame period guard; binned frames may come twice as fast
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_q <= '0;
    end else if (trig_ok) begin
      gap_q <= bin_sel ? GW'(FRAME_BIN_CYC - 1)
                       : GW'(FRAME_FULL_CYC - 1);
    end else if (gap_q != '0) begin
      gap_q <= gap_q - GW'(1);
    end
  end

  // Frame attributes latched per trigger
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bin_cur_q    <= 1'b0;
      sim_cur_q    <= 1'b0;
      frame_width  <= FULL_W;
      frame_height <= FULL_H;
    end else if (trig_ok) begin
      bin_cur_q    <= bin_sel;
      sim_cur_q    <= ctrl_q[CTRL_SIMEN];
      frame_width  <= bin_sel ? BIN_W : FULL_W;
      frame_height <= bin_sel ? BIN_H : FULL_H;
    end
  end

  assign frame_binned = bin_cur_q;
  assign frame_sim    = sim_cur_q;

  // Frame ready: end of exposure, or at once for a stored image
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_start <= 1'b0;
    end else begin
      frame_start <= (trig_ok && ctrl_q[CTRL_SIMEN]) ||
                     (state_q == ST_EXPOSE && exp_end);
    end
  end

  // Stored image and per-image set indices wrap cyclically
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sim_index <= '0;
      cfg_idx_q <= '0;
    end else if (trig_ok) begin
      if (ctrl_q[CTRL_SIMEN]) begin
        sim_index <= (sim_index + 8'h01 >= simn_q) ? 8'h00
                                                    : sim_index + 8'h01;
      end
      cfg_idx_q <= (cfg_idx_q == ctrl_q[CTRL_CFGN +: CFG_AW]) ? '0
                   : cfg_idx_q + CFG_AW'(1);
    end
  end

  // Ignored triggers, saturating, for diagnosis of overrun
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      miss_q <= '0;
    end else if (trigger && !trig_ok && miss_q != 8'hFF) begin
      miss_q <= miss_q + 8'h01;
    end
  end

  // Illumination; units without built-in lighting are always off
  assign ill_eff = HAS_INT_LIGHT ? est_illum_t'(ctrl_q[CTRL_ILL +: 2])
                                 : ILL_OFF;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led_on   <= 1'b0;
      led_high <= 1'b0;
    end else begin
      led_on   <= ill_eff == ILL_CONST ||
                  (ill_eff != ILL_OFF && state_d == ST_EXPOSE);
      led_high <= ill_eff == ILL_HIGH || ill_eff == ILL_CONST;
    end
  end

  // Checking helpers: measured widths of exposure and strobe
  logic [23:0] exp_seen_q, str_seen_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exp_seen_q <= '0;
      str_seen_q <= '0;
    end else begin
      exp_seen_q <= sensor_expose ? exp_seen_q + 24'h000001 : '0;
      str_seen_q <= strobe_q ? str_seen_q + 24'h000001 : '0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_sim_trig;
    trig_ok && ctrl_q[CTRL_SIMEN];
  endsequence
  sequence s_sim_frame;
    frame_start && frame_sim && !sensor_expose;
  endsequence

  property p_exp_clamp;
    exp_q >= EXP_MIN_US && exp_q <= EXP_MAX_US;
  endproperty
  property p_exp_len;
    $fell(sensor_expose) |-> exp_seen_q == 24'(exp_l_q) * 24'(US_CYC);
  endproperty
  property p_follow;
    !fixed_q && ctrl_q[CTRL_STREN] && sensor_expose |-> strobe_out3;
  endproperty
  property p_fixed_len;
    $fell(strobe_q) && fixed_q |-> str_seen_q == 24'(ont_l_q) * 24'(US_CYC);
  endproperty
  property p_delay_first;
    trig_ok && !ctrl_q[CTRL_SIMEN] && dly_q != '0
      |=> strobe_q && !sensor_expose;
  endproperty
  property p_bin_size;
    frame_binned |-> frame_width == BIN_W && frame_height == BIN_H;
  endproperty
  property p_gap;
    trig_ok |=> !trig_ok [*8];
  endproperty
  property p_cfg_bin;
    trig_ok && ctrl_q[CTRL_CFGDB] |=> bin_cur_q == $past(cfg_rdata[CFG_BIN]);
  endproperty
  property p_const;
    ill_eff == ILL_CONST |=> led_on && led_high;
  endproperty
  property p_no_light;
    !HAS_INT_LIGHT |-> !led_on;
  endproperty
  property p_sim;
    s_sim_trig |=> s_sim_frame;
  endproperty
  property p_tick;
    tick |=> !tick [*8];
  endproperty

  a_exp_clamp: assert property (p_exp_clamp) else $error("exp range");
  a_exp_len: assert property (p_exp_len) else $error("exp width");
  a_follow: assert property (p_follow) else $error("no strobe");
  a_fixed_len: assert property (p_fixed_len) else $error("on width");
  a_delay_first: assert property (p_delay_first) else $error("dly");
  a_bin_size: assert property (p_bin_size) else $error("bin size");
  a_gap: assert property (p_gap) else $error("fast trig");
  a_cfg_bin: assert property (p_cfg_bin) else $error("set bin");
  a_const: assert property (p_const) else $error("led const");
  a_no_light: assert property (p_no_light) else $error("led on");
  a_sim: assert property (p_sim) else $error("sim frame");
  a_tick: assert property (p_tick) else $error("tick spacing");
endmodule // est_timing

/* File: common/est_pkg.sv */
// Constants, register map and types for exposure and strobe timing
package est_pkg;
  // Time base
  localparam int unsigned CLK_HZ   = 40_000_000;
  localparam int unsigned US_PER_S = 1_000_000;
  localparam int unsigned US_CYC   = CLK_HZ / US_PER_S;
  localparam logic [5:0]  US_LAST  = 6'(US_CYC - 1);
  // Exposure limits in microseconds
  localparam int          TW         = 19;
  localparam logic [18:0] EXP_MIN_US = 19'h00010;
  localparam logic [18:0] EXP_MAX_US = 19'h61A80;
  localparam logic [18:0] EXP_RST_US = 19'h003E8;
  // Frame rates; least frame period rounds up
  localparam int unsigned FPS_FULL = 36;
  localparam int unsigned FPS_BIN  = 72;
  localparam int unsigned FRAME_FULL_CYC = (CLK_HZ + FPS_FULL - 1) / FPS_FULL;
  localparam int unsigned FRAME_BIN_CYC  = (CLK_HZ + FPS_BIN - 1) / FPS_BIN;
  localparam int          GW = 21;
  // Frame geometry
  localparam logic [11:0] FULL_W = 12'h9A0;
  localparam logic [11:0] FULL_H = 12'h800;
  localparam logic [11:0] BIN_W  = 12'h4D0;
  localparam logic [11:0] BIN_H  = 12'h400;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_EXP   = 8'h04;
  localparam logic [7:0] ADDR_ONT   = 8'h08;
  localparam logic [7:0] ADDR_DLY   = 8'h0C;
  localparam logic [7:0] ADDR_STAT  = 8'h10;
  localparam logic [7:0] ADDR_SIMN  = 8'h14;
  localparam logic [7:0] ADDR_CFG   = 8'h18;
  // Control fields
  localparam int CTRL_BIN   = 0;
  localparam int CTRL_SIMEN = 1;
  localparam int CTRL_STREN = 2;
  localparam int CTRL_CFGDB = 3;
  localparam int CTRL_ILL   = 4;
  localparam int CTRL_CFGN  = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0004;
  localparam logic [7:0]  SIMN_RST = 8'h01;
  // Per-image set store
  localparam int CFG_AW  = 4;
  localparam int CFG_DW  = 8;
  localparam int CFG_ADR = 16;
  localparam int CFG_BIN = 0;
  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ILL_OFF   = 2'b00,
    ILL_LOW   = 2'b01,
    ILL_HIGH  = 2'b10,
    ILL_CONST = 2'b11
  } est_illum_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_DELAY  = 2'b01,
    ST_EXPOSE = 2'b10,
    ST_HOLD   = 2'b11
  } est_state_t;
endpackage

/* File: verilog/est_cfg_mem.sv */
// Small store of per-image configuration sets
`timescale 1ns/1ps
module est_cfg_mem (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      we,
  input  wire logic [est_pkg::CFG_AW-1:0] waddr,
  input  wire logic [est_pkg::CFG_DW-1:0] wdata,
  input  wire logic [est_pkg::CFG_AW-1:0] raddr,
  output logic      [est_pkg::CFG_DW-1:0] rdata
);
  import est_pkg::*;

  logic [CFG_DW-1:0] mem_q [CFG_ADR];

  // Array write, no reset so it maps to RAM
  always_ff @(posedge aclk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  // Registered read, cleared only during reset; from the next cycle it shows the set at raddr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata <= '0;
    end else begin
      rdata <= mem_q[raddr];
    end
  end
endmodule // est_cfg_mem

/* File: tb/est_light_model.sv */
// Behavioural external strobe light controller with turn-on lag
`timescale 1ns/1ps
module est_light_model #(
  parameter int LAG = 100
) (
  input  wire logic aclk,
  input  wire logic strobe,
  output logic      light
);
  int cnt_q;

  // Lamp lights only after its own lag; dark again as soon as strobe drops
  always_ff @(posedge aclk) begin
    cnt_q <= strobe ? cnt_q + 1 : 0;
    light <= strobe && (cnt_q >= LAG - 1);
  end
endmodule // est_light_model

/* File: tb/est_timing_bench.sv */
// Self-checking bench for exposure and strobe timing
`timescale 1ns/1ps
module est_timing_bench;
  import est_pkg::*;
  localparam int FF = 2000;
  localparam int FB = 1000;
  typedef struct {
    int e; int s; logic d; logic b; logic sm; int si; int g;
  } est_note_t;

  logic        aclk, aresetn, trigger, light;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, sim_index;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        sensor_expose, strobe_out3, led_on, led_high;
  logic        frame_start, frame_sim, frame_binned, prev_exp;
  logic [11:0] frame_width, frame_height;
  int          n_errors, samples_checked, ne, ns, cyc, t_fs, last_si, k;
  int          seed;
  est_note_t   notes[$];
  est_note_t   n;
  logic [1:0]  bq[$];
  logic [33:0] rq[$];
  logic [33:0] r;

  est_timing #(.FRAME_FULL_CYC(FF), .FRAME_BIN_CYC(FB)) u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .trigger, .sensor_expose, .strobe_out3,
    .led_on, .led_high, .frame_start, .frame_sim, .frame_binned,
    .frame_width, .frame_height, .sim_index);

  est_light_model #(.LAG(100)) u_light (
    .aclk(aclk), .strobe(strobe_out3), .light(light));

  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic check(string nm, logic [31:0] seen, logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, want, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Write: address and data offered together, held until taken
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] rs);
    bq.push_back(rs);
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    do @(negedge aclk); while (s_axi_awready !== 1'b1);
    @(posedge aclk);
    s_axi_awvalid <= 1'b0; s_axi_wvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    @(posedge aclk) s_axi_bready <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] d, logic [1:0] rs);
    rq.push_back({rs, d});
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk) s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    @(posedge aclk) s_axi_rready <= 1'b0;
  endtask

  function automatic est_note_t mk(int e, int s, logic d, logic b,
                                   logic sm, int si, int g);
    est_note_t t;
    t = '{e, s, d, b, sm, si, g};
    return t;
  endfunction

  // One trigger pulse, then wait out the frame and its least period
  task automatic fire(est_note_t t);
    notes.push_back(t);
    @(posedge aclk) trigger <= 1'b1;
    @(posedge aclk) trigger <= 1'b0;
    for (k = 0; k < FF && notes.size() != 0; k++) @(posedge aclk);
    repeat (FF) @(posedge aclk);
  endtask

  // Watches outputs; pops the oldest note whenever a result appears
  always @(posedge aclk) begin
    cyc++;
    if (s_axi_bvalid && s_axi_bready) check("bresp", s_axi_bresp,
                                            bq.pop_front());
    if (s_axi_rvalid && s_axi_rready) begin
      r = rq.pop_front();
      check("rdata", s_axi_rdata, r[31:0]);
      check("rresp", s_axi_rresp, r[33:32]);
    end
    if (sensor_expose && !prev_exp && notes.size() != 0 && notes[0].d)
      check("light", light, 1'b1);
    prev_exp = sensor_expose;
    ne += sensor_expose;
    ns += strobe_out3;
    if (frame_start) begin
      n = notes.pop_front();
      check("exp_len", ne, n.e);
      check("str_len", ns, n.s);
      check("binned", frame_binned, n.b);
      check("width", frame_width, n.b ? BIN_W : FULL_W);
      check("height", frame_height, n.b ? BIN_H : FULL_H);
      check("sim", frame_sim, n.sm);
      check("led", {led_on, led_high}, 2'b00);
      if (n.si != 0) check("sim_idx", sim_index, (last_si + 1) % 3);
      if (n.g != 0) check("gap", cyc - t_fs <= FB + 2 && cyc - t_fs >= FB,
                          1'b1);
      last_si = sim_index;
      t_fs = cyc;
      ne = 0;
      ns = 0;
    end
  end

  // Hang guard, well beyond the expected run length
  initial begin
    repeat (90000) @(posedge aclk);
    n_errors++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    seed = 32'h6132A54D;
    {aresetn, trigger, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_CTRL, 32'h4, RESP_OKAY);
    rd(ADDR_EXP, 32'h3E8, RESP_OKAY);
    rd(ADDR_ONT, 32'h0, RESP_OKAY);
    rd(ADDR_DLY, 32'h0, RESP_OKAY);
    rd(ADDR_SIMN, 32'h1, RESP_OKAY);
    rd(8'h1C, 32'h0, RESP_SLVERR);
    wr(8'h1C, 32'hFFFF_FFFF, RESP_SLVERR);
    // Clamp at both ends, then a random legal value
    wr(ADDR_EXP, 32'hF, RESP_OKAY);
    rd(ADDR_EXP, 32'h10, RESP_OKAY);
    wr(ADDR_EXP, 32'h61A81, RESP_OKAY);
    rd(ADDR_EXP, 32'h61A80, RESP_OKAY);
    v = 32'h10 + ($unsigned($random(seed)) % 32'd399985);
    wr(ADDR_EXP, v, RESP_OKAY);
    rd(ADDR_EXP, v, RESP_OKAY);
    wr(ADDR_EXP, 32'h10, RESP_OKAY);
    fire(mk(640, 640, 0, 0, 0, 0, 0));
    wr(ADDR_ONT, 32'h5, RESP_OKAY);
    fire(mk(640, 200, 0, 0, 0, 0, 0));
    wr(ADDR_ONT, 32'h0, RESP_OKAY);
    wr(ADDR_DLY, 32'h3, RESP_OKAY);
    fire(mk(640, 760, 1, 0, 0, 0, 0));
    wr(ADDR_DLY, 32'h0, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    fire(mk(640, 0, 0, 0, 0, 0, 0));
    // Binned, trigger held so the second frame comes at the least period
    wr(ADDR_CTRL, 32'h5, RESP_OKAY);
    notes.push_back(mk(640, 640, 0, 1, 0, 0, 0));
    notes.push_back(mk(640, 640, 0, 1, 0, 0, 1));
    @(posedge aclk) trigger <= 1'b1;
    for (k = 0; k < 3 * FF && notes.size() != 0; k++) @(posedge aclk);
    trigger <= 1'b0;
    repeat (FF) @(posedge aclk);
    // Per-image sets: set 0 binned, set 1 full, used in turn
    wr(ADDR_CFG, 32'h0000_0001, RESP_OKAY);
    wr(ADDR_CFG, 32'h0001_0000, RESP_OKAY);
    rd(ADDR_CFG, 32'h0001_0001, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0000_010C, RESP_OKAY);
    fire(mk(640, 640, 0, 1, 0, 0, 0));
    fire(mk(640, 640, 0, 0, 0, 0, 0));
    // Constant brightness cannot light LEDs on this variant
    wr(ADDR_CTRL, 32'h34, RESP_OKAY);
    fire(mk(640, 640, 0, 0, 0, 0, 0));
    wr(ADDR_SIMN, 32'h3, RESP_OKAY);
    wr(ADDR_CTRL, 32'h6, RESP_OKAY);
    fire(mk(0, 0, 0, 0, 1, 0, 0));
    repeat (3) fire(mk(0, 0, 0, 0, 1, 1, 0));
    wr(ADDR_CTRL, 32'h4, RESP_OKAY);
    fire(mk(640, 640, 0, 0, 0, 0, 0));
    check("left", notes.size(), 32'h0);
    report_and_stop();
  end
endmodule // est_timing_bench
